// *** core/link_port_cfg.svh ***
/*
 Constants for the PHY-side link port: control pair encodings, request
 stream layout, status word layout and timing counts.
 Assumes inclusion by bare name from core files.
*/
`ifndef LINK_PORT_CFG_SVH
`define LINK_PORT_CFG_SVH

// PHY-driven control pair states
`define PHY_CTL_IDLE      2'h0
`define PHY_CTL_STATUS    2'h1
`define PHY_CTL_RECEIVE   2'h2
`define PHY_CTL_TRANSMIT  2'h3
// Link-driven control pair states
`define LNK_CTL_IDLE      2'h0
`define LNK_CTL_HOLD      2'h1
`define LNK_CTL_TRANSMIT  2'h2

// Request type codes on the serial request line
`define REQ_TYPE_READ     3'h4
`define REQ_TYPE_WRITE    3'h5
`define REQ_TYPE_W        3
`define REQ_ADDR_W        4
`define REQ_DATA_W        8
// Bits following the start bit for each stream kind (type+fields+stop)
`define REQ_LEN_BUS       5'h06
`define REQ_LEN_READ      5'h08
`define REQ_LEN_WRITE     5'h10

// Status word layout
`define STAT_FLAGS_W      4
`define STAT_WORD_W       16
`define STAT_BIT_ARB_GAP  0
`define STAT_BIT_SUB_GAP  1
`define STAT_BIT_BUS_RST  2
`define STAT_BIT_TIMEOUT  3
`define STAT_SHORT_BEATS  3'h2
`define STAT_FULL_BEATS   3'h7
`define PHY_ID_REG_ADDR   4'h0
`define REG_COUNT         16

// Chained packet wait before the PHY re-drives transmit
`define CHAIN_WAIT_NS     160
`define CLK_PERIOD_NS     20
`define CHAIN_WAIT_CYC    (((`CHAIN_WAIT_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))

`endif

// *** core/link_port_pkg.sv ***
/*
 Types for the PHY-side link port.
 Assumes the cfg header is compiled alongside.
*/
`default_nettype none
package link_port_pkg;
  typedef logic [1:0] ctl_t;
  typedef logic [3:0] reg_addr_t;
  typedef logic [7:0] reg_data_t;
  typedef enum logic [2:0] {
    PORT_IDLE    = 3'h0,
    PORT_STATUS  = 3'h1,
    PORT_GAP     = 3'h2,
    PORT_GRANT   = 3'h3,
    PORT_GRANT_I = 3'h4,
    PORT_LINK    = 3'h5,
    PORT_CHAIN   = 3'h6,
    PORT_RECV    = 3'h7
  } port_state_t;
endpackage : link_port_pkg
`default_nettype wire

// *** core/phy_link_port.sv ***
/*
 PHY side of the parallel link interface: register requests, status
 transfers, grants and link-driven transmission with hold and chaining.
 Assumes the link controller runs on the same sys_clk and that bus events,
 arbitration outcome come from the PHY core as pulses and packet arrival as a level.
*/
`include "link_port_cfg.svh"
`default_nettype none
module phy_link_port (
  input  wire logic                 sys_clk,             // System clock, 50 MHz
  input  wire logic                 resetn,              // Async reset, active low
  input  wire logic                 serial_request_line, // Link request stream
  input  wire logic [1:0]           control_pair_in,     // Control pair as driven by link
  output logic      [1:0]           control_pair_out,    // Control pair driven by PHY
  output logic                      control_pair_oe,     // High while PHY drives control
  input  wire logic [3:0]           parallel_data_in,    // Data lines from link
  output logic      [3:0]           parallel_data_out,   // Data lines from PHY
  output logic                      parallel_data_oe,    // High while PHY drives data
  input  wire logic                 arb_gap_evt,         // Arbitration-reset gap seen
  input  wire logic                 sub_gap_evt,         // Subaction gap seen
  input  wire logic                 bus_reset_evt,       // Bus reset state entered
  input  wire logic                 timeout_evt,         // State timeout or power loss
  input  wire logic                 self_id_done,        // Self-ID completed
  input  wire logic                 power_on_flag,       // Power-on reset in progress
  input  wire logic                 packet_arrival,      // Incoming packet, level
  input  wire logic                 arb_won,             // Arbitration won, pulse
  input  wire logic [7:0]           phy_id_value,        // Physical-ID register content
  output logic                      arb_request_q,       // Arbitrate for the link
  output logic                      data_on_q,           // Hold bus with data-on
  output logic                      tx_active_q,         // Link packet in progress
  output logic      [3:0]           tx_data_q,           // Link packet data captured
  output logic                      reg_wr_q,            // Register written, pulse
  output link_port_pkg::reg_addr_t  reg_wr_addr_q,       // Register address written
  output link_port_pkg::reg_data_t  reg_wr_data_q        // Register data written
);
  import link_port_pkg::*;

  port_state_t state_q, state_d;
  logic        bus_req, rd_req, wr_req;
  reg_addr_t   rq_addr;
  reg_data_t   rq_data;
  reg_data_t   regs_q [`REG_COUNT];
  logic [3:0]  flags_q;
  logic        full_pend_q;
  reg_addr_t   full_addr_q;
  logic        selfid_pend_q;
  logic        extra_selfid_q;
  logic [2:0]  beat_q;
  logic [2:0]  beats_q;
  logic [15:0] word_q;
  logic [3:0]  wait_q;
  logic [1:0]  ctl_q;
  logic        ctl_oe_q;
  logic [3:0]  dout_q;
  logic        dout_oe_q;

  request_receiver u_req (
    .sys_clk             (sys_clk),
    .resetn              (resetn),
    .serial_request_line (serial_request_line),
    .bus_req_q           (bus_req),
    .rd_req_q            (rd_req),
    .wr_req_q            (wr_req),
    .req_addr_q          (rq_addr),
    .req_data_q          (rq_data)
  );

  // Anything to report; short flags pending, a register read-back or a self-ID report
  wire        flag_pend = |flags_q;
  wire        want_stat = flag_pend || full_pend_q || selfid_pend_q;
  wire        link_hold = (control_pair_in == `LNK_CTL_HOLD);
  wire        link_tx   = (control_pair_in == `LNK_CTL_TRANSMIT);
  wire        link_idle = (control_pair_in == `LNK_CTL_IDLE);
  wire        stat_last = (beat_q == beats_q - 3'h1);
  wire        chain_done = (wait_q == 4'(`CHAIN_WAIT_CYC));
  // Register reported: self-ID forces the physical-ID register
  wire [3:0]  rep_addr  = selfid_pend_q ? `PHY_ID_REG_ADDR : full_addr_q;
  wire [7:0]  rep_data  = (rep_addr == `PHY_ID_REG_ADDR) ? phy_id_value : regs_q[full_addr_q];
  wire [15:0] new_word  = {rep_data, rep_addr, flags_q};
  wire        new_full  = full_pend_q || selfid_pend_q;

  // Port sequencing; receive and grant take priority over status
  always_comb begin
    state_d = state_q;
    case (state_q)
      PORT_IDLE: begin
        if (packet_arrival) state_d = PORT_RECV;
        else if (arb_won) state_d = PORT_GRANT;
        else if (want_stat) state_d = PORT_STATUS;
      end
      PORT_STATUS: begin
        if (packet_arrival) state_d = PORT_RECV;
        else if (stat_last) state_d = PORT_GAP;
      end
      PORT_GAP: state_d = packet_arrival ? PORT_RECV : PORT_IDLE;
      PORT_GRANT: state_d = PORT_GRANT_I;
      PORT_GRANT_I: state_d = PORT_LINK;
      PORT_LINK: begin
        if (link_idle && (tx_active_q || data_on_q)) state_d = PORT_IDLE;
        else if (link_hold && tx_active_q) state_d = PORT_CHAIN;
      end
      PORT_CHAIN: if (chain_done) state_d = PORT_LINK;
      PORT_RECV: if (!packet_arrival) state_d = PORT_IDLE;
      default: state_d = PORT_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) state_q <= PORT_IDLE;
    else state_q <= state_d;
  end

  // Register store: written once the whole stream is in
  generate
    for (genvar i = 0; i < `REG_COUNT; i++) begin : g_reg
      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) regs_q[i] <= 8'h00;
        else if (wr_req && rq_addr == 4'(i)) regs_q[i] <= rq_data;
      end
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      reg_wr_q      <= 1'b0;
      reg_wr_addr_q <= 4'h0;
      reg_wr_data_q <= 8'h00;
    end else begin
      reg_wr_q      <= wr_req;
      reg_wr_addr_q <= wr_req ? rq_addr : reg_wr_addr_q;
      reg_wr_data_q <= wr_req ? rq_data : reg_wr_data_q;
    end
  end

  // Pending status; an event in the sending cycle is kept, set wins
  wire stat_start = (state_q == PORT_IDLE) && (state_d == PORT_STATUS);
  wire stat_ok    = (state_q == PORT_STATUS) && stat_last && !packet_arrival;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      flags_q        <= 4'h0;
      full_pend_q    <= 1'b0;
      full_addr_q    <= 4'h0;
      selfid_pend_q  <= 1'b0;
      extra_selfid_q <= 1'b0;
    end else begin
      flags_q[`STAT_BIT_ARB_GAP] <= arb_gap_evt ||
        (flags_q[`STAT_BIT_ARB_GAP] && !(stat_ok && word_q[`STAT_BIT_ARB_GAP]));
      flags_q[`STAT_BIT_SUB_GAP] <= sub_gap_evt ||
        (flags_q[`STAT_BIT_SUB_GAP] && !(stat_ok && word_q[`STAT_BIT_SUB_GAP]));
      flags_q[`STAT_BIT_BUS_RST] <= bus_reset_evt ||
        (flags_q[`STAT_BIT_BUS_RST] && !(stat_ok && word_q[`STAT_BIT_BUS_RST]));
      flags_q[`STAT_BIT_TIMEOUT] <= timeout_evt ||
        (flags_q[`STAT_BIT_TIMEOUT] && !(stat_ok && word_q[`STAT_BIT_TIMEOUT]));
      // Read-back stays pending until delivered whole
      if (rd_req) begin
        full_pend_q <= 1'b1;
        full_addr_q <= rq_addr;
      end else if (stat_ok && beats_q == `STAT_FULL_BEATS + 3'h1 && !selfid_pend_q) begin
        full_pend_q <= 1'b0;
      end
      // Power-on self-ID is reported twice, later ones once
      if (self_id_done) begin
        selfid_pend_q  <= 1'b1;
        extra_selfid_q <= power_on_flag;
      end else if (stat_ok && selfid_pend_q && word_q[7:4] == `PHY_ID_REG_ADDR
                   && beats_q == `STAT_FULL_BEATS + 3'h1) begin
        selfid_pend_q  <= extra_selfid_q;
        extra_selfid_q <= 1'b0;
      end
    end
  end

  // Status word is latched at start; a cut transfer restarts from beat 0
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      beat_q  <= 3'h0;
      beats_q <= 3'h0;
      word_q  <= 16'h0000;
    end else if (stat_start) begin
      beat_q  <= 3'h0;
      beats_q <= new_full ? `STAT_FULL_BEATS + 3'h1 : `STAT_SHORT_BEATS;
      word_q  <= new_full ? new_word : {12'h000, flags_q};
    end else if (state_q == PORT_STATUS) begin
      beat_q <= beat_q + 3'h1;
    end else begin
      beat_q <= 3'h0;
    end
  end

  // Chain wait counter
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) wait_q <= 4'h0;
    else if (state_q == PORT_CHAIN) wait_q <= wait_q + 4'h1;
    else wait_q <= 4'h0;
  end

  // Link-side transmission tracking; same speed across chain is the link's duty
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      arb_request_q <= 1'b0;
      data_on_q     <= 1'b0;
      tx_active_q   <= 1'b0;
      tx_data_q     <= 4'h0;
    end else begin
      if (bus_req) arb_request_q <= 1'b1;
      else if (arb_won) arb_request_q <= 1'b0;
      data_on_q   <= (state_q == PORT_LINK || state_q == PORT_CHAIN) && link_hold;
      tx_active_q <= (state_q == PORT_LINK) && link_tx;
      tx_data_q   <= link_tx ? parallel_data_in : 4'h0;
    end
  end

  // Pin drive; PHY releases the pair while the link owns it
  wire [1:0] ctl_d = (state_d == PORT_STATUS) ? `PHY_CTL_STATUS :
                     (state_d == PORT_RECV)   ? `PHY_CTL_RECEIVE :
                     (state_d == PORT_GRANT)  ? `PHY_CTL_TRANSMIT :
                     (state_q == PORT_CHAIN && chain_done) ? `PHY_CTL_TRANSMIT :
                     `PHY_CTL_IDLE;
  wire       oe_d  = (state_d != PORT_LINK && state_d != PORT_CHAIN) ||
                     (state_q == PORT_CHAIN && chain_done);
  wire [15:0] start_word = new_full ? new_word : {12'h000, flags_q};
  wire [1:0] first_bits = start_word[1:0];
  wire [1:0] next_bits  = word_q[{beat_q + 3'h1, 1'b0} +: 2];
  wire [3:0] dout_d = (state_d == PORT_RECV) ? 4'hF :
                      (stat_start) ? {first_bits, 2'b00} :
                      (state_d == PORT_STATUS) ? {next_bits, 2'b00} : 4'h0;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ctl_q     <= `PHY_CTL_IDLE;
      ctl_oe_q  <= 1'b1;
      dout_q    <= 4'h0;
      dout_oe_q <= 1'b1;
    end else begin
      ctl_q     <= ctl_d;
      ctl_oe_q  <= oe_d;
      dout_q    <= dout_d;
      dout_oe_q <= oe_d;
    end
  end

  assign control_pair_out  = ctl_q;
  assign control_pair_oe   = ctl_oe_q;
  assign parallel_data_out = dout_q;
  assign parallel_data_oe  = dout_oe_q;
endmodule : phy_link_port
`default_nettype wire

// *** core/request_receiver.sv ***
/*
 Deserialiser for request streams on the serial request line.
 Assumes the line is synchronous to sys_clk and idles low.
*/
`include "link_port_cfg.svh"
`default_nettype none
module request_receiver (
  input  wire logic                    sys_clk,      // System clock
  input  wire logic                    resetn,       // Async reset, active low
  input  wire logic                    serial_request_line, // Request stream in
  output logic                         bus_req_q,    // Bus request seen, one pulse
  output logic                         rd_req_q,     // Read request seen, one pulse
  output logic                         wr_req_q,     // Write request seen, one pulse
  output link_port_pkg::reg_addr_t     req_addr_q,   // Addressed register
  output link_port_pkg::reg_data_t     req_data_q    // Write data byte
);
  import link_port_pkg::*;

  logic        busy_q;
  logic [4:0]  cnt_q;
  logic [15:0] shift_q;
  logic [4:0]  len_q;

  // Length follows the type code once its three bits are in
  wire [2:0]  type_w   = shift_q[2:0];
  wire        type_in  = busy_q && (cnt_q == 5'h04);
  wire [4:0]  len_sel  = (type_w == `REQ_TYPE_READ)  ? `REQ_LEN_READ :
                         (type_w == `REQ_TYPE_WRITE) ? `REQ_LEN_WRITE : `REQ_LEN_BUS;
  wire [4:0]  len_w    = type_in ? len_sel : len_q;
  wire        last_bit = busy_q && (cnt_q == len_w);
  wire [2:0]  rx_type  = (len_w == `REQ_LEN_WRITE) ? shift_q[14:12] :
                         (len_w == `REQ_LEN_READ)  ? shift_q[6:4] : shift_q[4:2];

  // Streams are taken at any time, whatever the port state
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      busy_q     <= 1'b0;
      cnt_q      <= 5'h00;
      shift_q    <= 16'h0000;
      len_q      <= 5'h00;
      bus_req_q  <= 1'b0;
      rd_req_q   <= 1'b0;
      wr_req_q   <= 1'b0;
      req_addr_q <= 4'h0;
      req_data_q <= 8'h00;
    end else begin
      bus_req_q <= 1'b0;
      rd_req_q  <= 1'b0;
      wr_req_q  <= 1'b0;
      if (!busy_q) begin
        busy_q <= serial_request_line; // Start bit of 1
        cnt_q  <= 5'h01;
      end else begin
        shift_q <= {shift_q[14:0], serial_request_line};
        cnt_q   <= cnt_q + 5'h01;
        len_q   <= len_w;
        if (last_bit) begin
          // Stop bit is this sample, not yet shifted in; fields end at bit 0
          busy_q     <= 1'b0;
          bus_req_q  <= (len_w == `REQ_LEN_BUS) && !rx_type[2];
          rd_req_q   <= (len_w == `REQ_LEN_READ) && (rx_type == `REQ_TYPE_READ);
          wr_req_q   <= (len_w == `REQ_LEN_WRITE) && (rx_type == `REQ_TYPE_WRITE);
          req_addr_q <= (len_w == `REQ_LEN_WRITE) ? shift_q[11:8] : shift_q[3:0];
          req_data_q <= shift_q[7:0];
        end
      end
    end
  end
endmodule : request_receiver
`default_nettype wire

// *** verification/link_model.sv ***
/*
 Behavioural link controller: request streams, hold, transmit, chaining.
 Assumes the PHY clock; released lines toggle so stale values never pass.
*/
`include "link_port_cfg.svh"
`default_nettype none
module link_model (
  input  wire logic       sys_clk,             // System clock
  input  wire logic [1:0] control_pair_out,    // PHY control drive
  input  wire logic       control_pair_oe,     // PHY owns control
  output logic            serial_request_line, // Request stream out
  output logic      [1:0] control_pair_in,     // Link control drive
  output logic      [3:0] parallel_data_in     // Link data drive
);
  timeunit 1ns;
  timeprecision 100ps;
  logic drive_q; // Link owns control and data

  initial begin
    drive_q = 1'b0;
    serial_request_line = 1'b0;
    control_pair_in = `LNK_CTL_IDLE;
    parallel_data_in = 4'h0;
  end

  // Undriven lines invert every cycle; 00 and 11 never look like hold
  always @(negedge sys_clk) begin
    if (!drive_q) begin
      control_pair_in  <= ~control_pair_in;
      parallel_data_in <= ~parallel_data_in;
    end
  end

  // Bits go out first to last; the line then rests low
  task automatic shift_out(input logic [16:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      serial_request_line <= v[16 - i];
      @(posedge sys_clk);
    end
    serial_request_line <= 1'b0;
  endtask : shift_out
  task automatic req_bus(input logic [6:0] v);
    shift_out({v, 10'h000}, 7);
  endtask : req_bus
  task automatic req_read(input logic [8:0] v);
    shift_out({v, 8'h00}, 9);
  endtask : req_read
  task automatic req_write(input logic [16:0] v);
    shift_out(v, 17);
  endtask : req_write

  // One cycle of drive on the pair and the data lines
  task automatic drive(input logic [1:0] c, input logic [3:0] d);
    drive_q          <= 1'b1;
    control_pair_in  <= c;
    parallel_data_in <= d;
    @(posedge sys_clk);
  endtask : drive

  // Transmit beats, then idle and let go, or hold to chain at one speed
  task automatic packet(input int beats, input logic chain);
    for (int i = 0; i < beats; i++) begin
      drive(`LNK_CTL_TRANSMIT, 4'(i) ^ 4'hA);
    end
    if (chain) begin
      drive(`LNK_CTL_HOLD, 4'h0);
    end else begin
      drive(`LNK_CTL_IDLE, 4'h0);
      drive_q          <= 1'b0;
    end
  endtask : packet
endmodule : link_model
`default_nettype wire

// *** verification/phy_link_port_properties.sv ***
/*
 Checker for the PHY link port: status and grant sequencing, request
 stream framing and capture of link drive.
 Assumes it is bound into phy_link_port and sees only its ports.
*/
`include "link_port_cfg.svh"
`default_nettype none
module phy_link_port_check (
  input wire logic       sys_clk,             // System clock
  input wire logic       resetn,              // Async reset, active low
  input wire logic       serial_request_line, // Link request stream
  input wire logic [1:0] control_pair_in,     // Link control drive
  input wire logic [1:0] control_pair_out,    // PHY control drive
  input wire logic       control_pair_oe,     // PHY owns control
  input wire logic [3:0] parallel_data_in,    // Link data
  input wire logic [3:0] parallel_data_out,   // PHY data
  input wire logic       packet_arrival,      // Incoming packet
  input wire logic       arb_won,             // Arbitration won
  input wire logic       arb_request_q,       // Arbitration pending
  input wire logic       data_on_q,           // Link holding
  input wire logic       tx_active_q,         // Link transmitting
  input wire logic [3:0] tx_data_q,           // Captured link data
  input wire logic       reg_wr_q             // Register write pulse
);
  timeunit 1ns;
  timeprecision 100ps;
  // Who owns the pair and what it shows
  wire status_w = control_pair_oe && (control_pair_out == `PHY_CTL_STATUS);
  wire idle_w   = control_pair_oe && (control_pair_out == `PHY_CTL_IDLE);
  wire link_w   = !control_pair_oe;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  // An idle cycle before every status start also spaces transfers apart
  a_status_from_idle:
    assert property ($rose(status_w) |-> $past(idle_w))
      else $error("status started without an idle cycle before it");
  a_status_two_beats:
    assert property ($rose(status_w) && !packet_arrival |=> status_w)
      else $error("status dropped after a single beat");
  a_status_abort:
    assert property (status_w && packet_arrival |=> control_pair_out == `PHY_CTL_RECEIVE && parallel_data_out == 4'hF)
      else $error("packet did not cut the status transfer");
  // Grant only counts from a quiet port; otherwise a receive may win
  a_grant_sequence:
    assert property (arb_won && idle_w && !packet_arrival |=>
      control_pair_oe && control_pair_out == `PHY_CTL_TRANSMIT ##1 idle_w ##1 link_w)
      else $error("grant was not transmit, idle, release");
  a_arb_cleared:
    assert property (arb_won |=> !arb_request_q)
      else $error("arbitration request stayed after the win");
  a_write_framed:
    assert property (reg_wr_q |-> $past(serial_request_line, 18) && $past(serial_request_line, 17)
      && !$past(serial_request_line, 16) && $past(serial_request_line, 15) && !$past(serial_request_line, 2))
      else $error("register write without a framed write stream");
  a_hold_data_on:
    assert property (link_w && control_pair_in == `LNK_CTL_HOLD |=> data_on_q)
      else $error("link hold did not keep data-on");
  a_tx_capture:
    assert property (link_w && control_pair_in == `LNK_CTL_TRANSMIT |=> tx_active_q && tx_data_q == $past(parallel_data_in))
      else $error("link transmit data not captured");
endmodule : phy_link_port_check

bind phy_link_port phy_link_port_check u_chk (
  .sys_clk(sys_clk), .resetn(resetn), .serial_request_line(serial_request_line),
  .control_pair_in(control_pair_in), .control_pair_out(control_pair_out), .control_pair_oe(control_pair_oe),
  .parallel_data_in(parallel_data_in), .parallel_data_out(parallel_data_out), .packet_arrival(packet_arrival),
  .arb_won(arb_won), .arb_request_q(arb_request_q), .data_on_q(data_on_q), .tx_active_q(tx_active_q),
  .tx_data_q(tx_data_q), .reg_wr_q(reg_wr_q)
);
`default_nettype wire

// *** verification/testbench.sv ***
/*
 Self-checking bench for phy_link_port with the link controller model.
 Assumes the checker binds itself in; all waits are bounded.
*/
`include "link_port_cfg.svh"
`default_nettype none
`define CHK(nm, ex, gt) begin tests_run++; if ((gt) !== (ex)) begin errors++; $display("BAD %s expected %0h seen %0h", nm, ex, gt); end end
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import link_port_pkg::*;
  logic        sys_clk, resetn, packet_arrival, arb_won, self_id_done, power_on_flag;
  logic        arb_gap_evt, sub_gap_evt, bus_reset_evt, timeout_evt;
  logic [7:0]  phy_id_value;
  logic        serial_request_line, control_pair_oe, parallel_data_oe, arb_request_q, data_on_q, tx_active_q, reg_wr_q;
  logic [1:0]  control_pair_in, control_pair_out;
  logic [3:0]  parallel_data_in, parallel_data_out, tx_data_q;
  reg_addr_t   reg_wr_addr_q;
  reg_data_t   reg_wr_data_q;
  int          errors = 0;
  int          tests_run = 0;
  logic [31:0] rng = 32'h42B392AA;

  phy_link_port dut (.sys_clk(sys_clk), .resetn(resetn), .serial_request_line(serial_request_line),
    .control_pair_in(control_pair_in), .control_pair_out(control_pair_out), .control_pair_oe(control_pair_oe),
    .parallel_data_in(parallel_data_in), .parallel_data_out(parallel_data_out), .parallel_data_oe(parallel_data_oe),
    .arb_gap_evt(arb_gap_evt), .sub_gap_evt(sub_gap_evt), .bus_reset_evt(bus_reset_evt), .timeout_evt(timeout_evt),
    .self_id_done(self_id_done), .power_on_flag(power_on_flag), .packet_arrival(packet_arrival), .arb_won(arb_won),
    .phy_id_value(phy_id_value), .arb_request_q(arb_request_q), .data_on_q(data_on_q), .tx_active_q(tx_active_q),
    .tx_data_q(tx_data_q), .reg_wr_q(reg_wr_q), .reg_wr_addr_q(reg_wr_addr_q), .reg_wr_data_q(reg_wr_data_q));
  link_model lm (.sys_clk(sys_clk), .control_pair_out(control_pair_out), .control_pair_oe(control_pair_oe),
    .serial_request_line(serial_request_line), .control_pair_in(control_pair_in), .parallel_data_in(parallel_data_in));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] next_rand();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : next_rand
  // Full status word: data, address, flags from the top
  function automatic logic [15:0] full_word(logic [3:0] f, reg_addr_t a, reg_data_t d);
    return {d, a, f};
  endfunction : full_word

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test
  task automatic do_reset();
    resetn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    `CHK("control_pair_out", `PHY_CTL_IDLE, control_pair_out)
    resetn <= 1'b1;
    @(posedge sys_clk);
  endtask : do_reset
  // Outputs are read just after an edge, so they show the settled cycle
  task automatic wait_ctl(input logic [1:0] v, output int n);
    n = 0;
    while (!(control_pair_oe === 1'b1 && control_pair_out === v)) begin
      @(posedge sys_clk);
      n++;
      if (n > 300) begin
        errors++;
        finish_test();
      end
    end
  endtask : wait_ctl
  task automatic get_status(output int b, output logic [15:0] w);
    int n;
    wait_ctl(`PHY_CTL_STATUS, n);
    b = 0;
    w = 16'h0000;
    while (control_pair_oe === 1'b1 && control_pair_out === `PHY_CTL_STATUS && b < 8) begin
      w[2 * b +: 2] = parallel_data_out[3:2];
      b++;
      @(posedge sys_clk);
    end
  endtask : get_status
  task automatic grant();
    int n;
    lm.req_bus({1'b1, 3'h3, 2'h1, 1'b0});
    repeat (2) @(posedge sys_clk);
    `CHK("arb_request_q", 1'b1, arb_request_q)
    arb_won <= 1'b1;
    @(posedge sys_clk);
    arb_won <= 1'b0;
    wait_ctl(`PHY_CTL_TRANSMIT, n);
    @(posedge sys_clk);
  endtask : grant
  task automatic check_write(input reg_addr_t a, input reg_data_t d);
    repeat (40) if (reg_wr_q !== 1'b1) @(posedge sys_clk);
    if (reg_wr_q !== 1'b1) begin
      errors++;
      finish_test();
    end
    `CHK("reg_wr_addr_q", a, reg_wr_addr_q)
    `CHK("reg_wr_data_q", d, reg_wr_data_q)
  endtask : check_write

  initial begin
    int          b, n;
    logic [15:0] w;
    logic [3:0]  m;
    reg_addr_t   a;
    reg_data_t   d;
    {packet_arrival, arb_won, self_id_done, power_on_flag} = 4'h0;
    {timeout_evt, bus_reset_evt, sub_gap_evt, arb_gap_evt} = 4'h0;
    phy_id_value = 8'h00;
    do_reset();
    phy_id_value <= 8'(next_rand());
    // Each flag alone, then random mixes
    for (int i = 0; i < 8; i++) begin
      m = (i < 4) ? (4'h1 << i) : 4'(next_rand());
      m = (m == 4'h0) ? 4'hF : m;
      {timeout_evt, bus_reset_evt, sub_gap_evt, arb_gap_evt} <= m;
      @(posedge sys_clk);
      {timeout_evt, bus_reset_evt, sub_gap_evt, arb_gap_evt} <= 4'h0;
      get_status(b, w);
      `CHK("short_beats", 2, b)
      `CHK("status_flags", m, w[3:0])
    end
    // Register read, plain and cut short by an arriving packet
    for (int i = 0; i < 2; i++) begin
      lm.req_read({1'b1, `REQ_TYPE_READ, `PHY_ID_REG_ADDR, 1'b0});
      if (i == 1) begin
        wait_ctl(`PHY_CTL_STATUS, n);
        packet_arrival <= 1'b1;
        repeat (4) @(posedge sys_clk);
        `CHK("receive_state", `PHY_CTL_RECEIVE, control_pair_out)
        packet_arrival <= 1'b0;
      end
      get_status(b, w);
      `CHK("full_beats", 8, b)
      `CHK("read_word", full_word(4'h0, `PHY_ID_REG_ADDR, phy_id_value), w)
    end
    // Self-ID reports: two after power-on, one otherwise, none further
    for (int p = 1; p >= 0; p--) begin
      power_on_flag <= 1'(p);
      self_id_done <= 1'b1;
      @(posedge sys_clk);
      self_id_done <= 1'b0;
      for (int k = 0; k <= p; k++) begin
        get_status(b, w);
        `CHK("self_id_addr", 4'h0, w[7:4])
        `CHK("self_id_data", phy_id_value, w[15:8])
      end
      n = 0;
      repeat (60) begin
        @(posedge sys_clk);
        n += (control_pair_oe === 1'b1 && control_pair_out === `PHY_CTL_STATUS);
      end
      `CHK("extra_self_id", 0, n)
    end
    // Grant with hold and a write arriving mid-packet, then a chained pair
    grant();
    a = 4'(next_rand());
    d = 8'(next_rand());
    fork
      begin
        lm.req_write({1'b1, `REQ_TYPE_WRITE, a, d, 1'b0});
        check_write(a, d);
      end
      begin
        repeat (3) lm.drive(`LNK_CTL_HOLD, 4'h0);
        `CHK("data_on_q", 1'b1, data_on_q)
        `CHK("parallel_data_oe", 1'b0, parallel_data_oe)
        lm.packet(6, 1'b0);
        wait_ctl(`PHY_CTL_IDLE, n);
      end
    join
    grant();
    lm.packet(4, 1'b1);
    wait_ctl(`PHY_CTL_TRANSMIT, n);
    `CHK("chain_wait", 1'b1, n >= `CHAIN_WAIT_CYC && n <= `CHAIN_WAIT_CYC + 3)
    lm.packet(4, 1'b0);
    wait_ctl(`PHY_CTL_IDLE, n);
    // Second reset, then writes from the first allowed edge, corners first
    do_reset();
    for (int i = 0; i < 4; i++) begin
      a = (i == 0) ? 4'hF : 4'(next_rand());
      d = (i == 0) ? 8'hFF : 8'(next_rand());
      lm.req_write({1'b1, `REQ_TYPE_WRITE, a, d, 1'b0});
      check_write(a, d);
    end
    finish_test();
  end
endmodule : testbench
`default_nettype wire
